//--- csp_pkg.sv
// Constants and types of the configuration serial port
`default_nettype none

package csp_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W    = 6;
	localparam int DATA_W    = 8;
	localparam int REG_COUNT = 64;
	localparam int PIN_COUNT = 3;

	// ----------------------------------------------------------------
	// Pin slots in the synchroniser
	// ----------------------------------------------------------------
	localparam int PIN_SCK = 0;
	localparam int PIN_SEL = 1;
	localparam int PIN_DAT = 2;
	localparam logic [2:0] PIN_RST_VAL = 3'h2;

	// ----------------------------------------------------------------
	// Header layout
	// ----------------------------------------------------------------
	localparam int HDR_RNW_BIT  = 7;
	localparam int HDR_ADDR_MSB = 6;
	localparam int HDR_ADDR_LSB = 1;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// ----------------------------------------------------------------
	// Register addresses and control bits
	// ----------------------------------------------------------------
	localparam logic [5:0] ADDR_CK_CTRL  = 6'h14;
	localparam logic [5:0] ADDR_CKFA_HI  = 6'h15;
	localparam logic [5:0] ADDR_CKFA_LO  = 6'h16;
	localparam logic [5:0] ADDR_SSI_A    = 6'h18;
	localparam logic [5:0] ADDR_SSI_B    = 6'h19;
	localparam logic [5:0] ADDR_SSI_DIV  = 6'h1a;
	localparam logic [5:0] ADDR_RD_EN    = 6'h3a;
	localparam logic [5:0] ADDR_TRI      = 6'h3b;
	localparam logic [5:0] ADDR_REV      = 6'h3f;
	localparam int FOUR_WIRE_BIT = 7;
	localparam int RD_EN_BIT     = 3;
	localparam int TRI_BIT       = 3;
	localparam logic [7:0] SOFT_RST_KEY = 8'h99;

	// Bit n set: address n is the high byte of a two-byte register
	localparam logic [63:0] PAIR_MSB_MASK = 64'h0000_0000_0020_0000;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CK_CTRL = 8'h03;
	localparam logic [7:0] RST_CKFA_LO = 8'h04;
	localparam logic [7:0] RST_SSI_A   = 8'h12;
	localparam logic [7:0] RST_SSI_B   = 8'h07;
	localparam logic [7:0] RST_SSI_DIV = 8'h01;
	localparam logic [7:0] RST_OTHER   = 8'h00;

	function automatic logic [7:0] resetVal(input logic [5:0] a);
		case (a)
			ADDR_CK_CTRL: resetVal = RST_CK_CTRL;
			ADDR_CKFA_LO: resetVal = RST_CKFA_LO;
			ADDR_SSI_A:   resetVal = RST_SSI_A;
			ADDR_SSI_B:   resetVal = RST_SSI_B;
			ADDR_SSI_DIV: resetVal = RST_SSI_DIV;
			default:      resetVal = RST_OTHER;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Port state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CSP_HDR,
		CSP_WR,
		CSP_RD,
		CSP_DONE
	} csp_state_e;

endpackage

`default_nettype wire

//--- csp_pin_if.sv
// Raw and filtered pin levels between the port and its synchroniser
`default_nettype none

interface csp_pin_if;
	logic [csp_pkg::PIN_COUNT-1:0] raw;
	logic [csp_pkg::PIN_COUNT-1:0] stable;

	modport filt (input raw, output stable);
	modport core (output raw, input stable);
endinterface

`default_nettype wire

//--- csp_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none

module csp_pin_sync #(
	parameter logic [csp_pkg::PIN_COUNT-1:0] RST_VAL = csp_pkg::PIN_RST_VAL
) (
	// Clock and reset
	input  wire logic     clk,
	input  wire logic     rst_n,
	// Pins
	csp_pin_if.filt       pins
);

	logic [csp_pkg::PIN_COUNT-1:0] stable_q;

	genvar g;
	generate
		for (g = 0; g < csp_pkg::PIN_COUNT; g++) begin : g_pin
			logic [2:0] stg_q;
			// Stage 0 feeds stage 1 only; level moves when stages 1 and 2 agree
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					stg_q       <= {3{RST_VAL[g]}};
					stable_q[g] <= RST_VAL[g];
				end else begin
					stg_q <= {stg_q[1:0], pins.raw[g]};
					if (stg_q[1] == stg_q[2]) begin
						stable_q[g] <= stg_q[2];
					end
				end
			end
		end
	endgenerate

	assign pins.stable = stable_q;

endmodule

`default_nettype wire

//--- csp_config_serial_port.sv
// Configuration serial port: header decode, register file, readback
//
// Function
// R1: Three wires by default: host shift clock, active-low select, shared data line.
// R2: Bit 7 of register 0x19 enables four-wire mode with separate readback output.
// R3: Readback output driven low after power-up; bit 3 of 0x3B floats it.
// R4: Each transfer starts with an 8-bit header; data follows directly.
// R5: Header bit 7 is read flag, bits 6..1 address, bit 0 ignored.
// R6: Address and data travel most significant bit first.
// R7: With select low, header bits are sampled on rising shift clock edges.
// R8: Low read flag writes; eight data bits sampled on next eight rising edges.
// R9: Select rising before a full write byte aborts it; register unchanged.
// R10: Select held low another eight cycles increments address, stores next byte.
// R11: Two-byte registers big-endian; new value takes effect with low byte.
// R12: Three-wire reads need read enable, bit 3 of register 0x3A.
// R13: High read flag reads; eight bits driven on next eight falling edges.
// R14: Four-wire mode copies read bits to readback output with same timing.
// R15: After select rises the data line is released and is input again.
// R16: Reads never increment; each read needs its own header and select.
// R17: Writing 0x99 to revision register 0x3F acts as power-on reset.
// R18: Select high clears bit counter and header state for a fresh header.
`default_nettype none

module csp_config_serial_port #(
	parameter logic [7:0]  REV_ID        = 8'h5a,  // Arbitrary revision code
	parameter logic [63:0] PAIR_MSB_MASK = csp_pkg::PAIR_MSB_MASK
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Serial pins
	input  wire logic        configShiftClock,
	input  wire logic        configSelectN,
	input  wire logic        configDataIn,
	output logic             configDataOut,
	output logic             configDataOe,
	output logic             configReadbackOut,
	output logic             configReadbackOe,
	// Register contents to the rest of the device
	output logic [511:0]     cfgRegs
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	generate
		if (PAIR_MSB_MASK[csp_pkg::ADDR_REV] || PAIR_MSB_MASK[csp_pkg::REG_COUNT-1]) begin : g_bad_mask
			$error("Pair mask may not cover the revision or last address");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic logic isPairMsb(input logic [5:0] a);
		isPairMsb = PAIR_MSB_MASK[a];
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	csp_pin_if pins ();

	assign pins.raw[csp_pkg::PIN_SCK] = configShiftClock;
	assign pins.raw[csp_pkg::PIN_SEL] = configSelectN;
	assign pins.raw[csp_pkg::PIN_DAT] = configDataIn;

	csp_pin_sync #(
		.RST_VAL (csp_pkg::PIN_RST_VAL)
	) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.pins  (pins.filt)
	);

	logic sck;
	logic selN;
	logic sdi;
	logic sckPrev_q;
	logic sckRise;
	logic sckFall;

	assign sck     = pins.stable[csp_pkg::PIN_SCK];
	assign selN    = pins.stable[csp_pkg::PIN_SEL];
	assign sdi     = pins.stable[csp_pkg::PIN_DAT];
	assign sckRise = sck & ~sckPrev_q;
	assign sckFall = ~sck & sckPrev_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sckPrev_q <= 1'b0;
		end else begin
			sckPrev_q <= sck;
		end
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	csp_pkg::csp_state_e state_q;
	logic [2:0]          bitCnt_q;
	logic [7:0]          shIn_q;
	logic [5:0]          addr_q;
	logic [7:0]          shOut_q;
	logic [7:0]          regs_q [csp_pkg::REG_COUNT];
	logic [7:0]          shadow_q;
	logic                softRst_q;
	logic                dataOut_q;
	logic                dataOe_q;
	logic                rbOut_q;

	logic [7:0]          inByte;
	logic [5:0]          hdrAddr;
	logic                hdrRead;
	logic                hdrDone;
	logic                wrCommit;
	logic                fourWire;
	logic                rdEnable;
	logic                rbFloat;
	logic                readAllowed;

	// Serial byte assembled MSB first [R6]
	assign inByte  = {shIn_q[6:0], sdi};
	assign hdrRead = inByte[csp_pkg::HDR_RNW_BIT];                        // [R5]
	assign hdrAddr = inByte[csp_pkg::HDR_ADDR_MSB:csp_pkg::HDR_ADDR_LSB]; // [R5]

	assign hdrDone  = !selN && sckRise && state_q == csp_pkg::CSP_HDR
	                  && bitCnt_q == csp_pkg::LAST_BIT;                    // [R4]
	assign wrCommit = !selN && sckRise && state_q == csp_pkg::CSP_WR
	                  && bitCnt_q == csp_pkg::LAST_BIT;                    // [R8] [R9]

	assign fourWire    = regs_q[csp_pkg::ADDR_SSI_B][csp_pkg::FOUR_WIRE_BIT];
	assign rdEnable    = regs_q[csp_pkg::ADDR_RD_EN][csp_pkg::RD_EN_BIT];
	assign rbFloat     = regs_q[csp_pkg::ADDR_TRI][csp_pkg::TRI_BIT];
	// Four-wire reads need no enable; readback pin is their path
	assign readAllowed = rdEnable | fourWire;                             // [R12]

	// ----------------------------------------------------------------
	// Transfer sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= csp_pkg::CSP_HDR;
			bitCnt_q <= 3'h0;
		end else if (selN) begin
			state_q  <= csp_pkg::CSP_HDR;                                 // [R18]
			bitCnt_q <= 3'h0;
		end else if (sckRise) begin
			case (state_q)
				csp_pkg::CSP_HDR: begin
					bitCnt_q <= bitCnt_q + 3'h1;                          // [R7]
					if (bitCnt_q == csp_pkg::LAST_BIT) begin
						if (!hdrRead) begin
							state_q <= csp_pkg::CSP_WR;                   // [R8]
						end else if (readAllowed) begin
							state_q <= csp_pkg::CSP_RD;                   // [R13]
						end else begin
							state_q <= csp_pkg::CSP_DONE;                 // [R12]
						end
					end
				end
				csp_pkg::CSP_WR: begin
					// Counter wraps, so each further eight clocks is a new byte
					bitCnt_q <= bitCnt_q + 3'h1;                          // [R10]
				end
				csp_pkg::CSP_RD: begin
					bitCnt_q <= bitCnt_q;
				end
				csp_pkg::CSP_DONE: begin
					bitCnt_q <= bitCnt_q;
				end
				default: begin
					state_q <= csp_pkg::CSP_DONE;
				end
			endcase
		end else if (sckFall && state_q == csp_pkg::CSP_RD) begin
			bitCnt_q <= bitCnt_q + 3'h1;
			if (bitCnt_q == csp_pkg::LAST_BIT) begin
				// One byte only; a new header needs a new select
				state_q <= csp_pkg::CSP_DONE;                             // [R16]
			end
		end
	end

	// ----------------------------------------------------------------
	// Input shifter and address
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shIn_q <= 8'h00;
		end else if (selN) begin
			shIn_q <= 8'h00;
		end else if (sckRise) begin
			shIn_q <= inByte;                                             // [R7] [R8]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_q <= 6'h00;
		end else if (hdrDone) begin
			addr_q <= hdrAddr;
		end else if (wrCommit) begin
			addr_q <= addr_q + 6'h01;                                     // [R10]
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	// Revision code is a key, not storage: the 0x99 write only resets
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			softRst_q <= 1'b0;
		end else begin
			softRst_q <= wrCommit && addr_q == csp_pkg::ADDR_REV
			             && inByte == csp_pkg::SOFT_RST_KEY;              // [R17]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shadow_q <= 8'h00;
		end else if (softRst_q) begin
			shadow_q <= 8'h00;
		end else if (wrCommit && isPairMsb(addr_q)) begin
			shadow_q <= inByte;                                           // [R11]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < csp_pkg::REG_COUNT; i++) begin
				regs_q[i] <= csp_pkg::resetVal(6'(i));
			end
		end else if (softRst_q) begin
			for (int i = 0; i < csp_pkg::REG_COUNT; i++) begin
				regs_q[i] <= csp_pkg::resetVal(6'(i));                    // [R17]
			end
		end else if (wrCommit && addr_q != csp_pkg::ADDR_REV && !isPairMsb(addr_q)) begin
			regs_q[addr_q] <= inByte;                                     // [R8]
			// High byte lands together with its low byte
			if (isPairMsb(addr_q - 6'h01)) begin
				regs_q[addr_q - 6'h01] <= shadow_q;                       // [R11]
			end
		end
	end

	genvar r;
	generate
		for (r = 0; r < csp_pkg::REG_COUNT; r++) begin : g_out
			assign cfgRegs[r*8 +: 8] = regs_q[r];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shOut_q <= 8'h00;
		end else if (hdrDone) begin
			shOut_q <= (hdrAddr == csp_pkg::ADDR_REV) ? REV_ID : regs_q[hdrAddr];
		end else if (sckFall && state_q == csp_pkg::CSP_RD) begin
			shOut_q <= {shOut_q[6:0], 1'b0};                              // [R6]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dataOut_q <= 1'b0;
			rbOut_q   <= 1'b0;
		end else if (selN) begin
			dataOut_q <= 1'b0;
			rbOut_q   <= 1'b0;
		end else if (sckFall && state_q == csp_pkg::CSP_RD) begin
			dataOut_q <= shOut_q[7];                                      // [R13]
			rbOut_q   <= fourWire & shOut_q[7];                           // [R14] [R2]
		end
	end

	// Line stays driven after the eighth bit until the host lets go
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dataOe_q <= 1'b0;
		end else if (selN) begin
			dataOe_q <= 1'b0;                                             // [R15]
		end else if (hdrDone && hdrRead && readAllowed) begin
			dataOe_q <= 1'b1;                                             // [R1] [R12]
		end
	end

	assign configDataOut     = dataOut_q;
	assign configDataOe      = dataOe_q;
	assign configReadbackOut = rbOut_q;                                   // [R3]
	assign configReadbackOe  = ~rbFloat;                                  // [R3]

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_hdr_sample: assert property (!selN && sckRise && state_q == csp_pkg::CSP_HDR |=> shIn_q[0] == $past(sdi)) // [R7]
		else $error("Header bit not sampled on rising edge");

	a_sel_release: assert property (selN |=> !configDataOe && bitCnt_q == 3'h0 // [R15]
	                                && state_q == csp_pkg::CSP_HDR)
		else $error("Select high did not release and clear the port");

	a_sel_clear: assert property ($rose(selN) |=> state_q == csp_pkg::CSP_HDR ##1 // [R18]
	                              state_q == csp_pkg::CSP_HDR)
		else $error("Header state not cleared while select high");

	// Cut bytes must leave every register as it was
	a_wr_abort: assert property (selN && !softRst_q |=> $stable(cfgRegs)) // [R9]
		else $error("Register changed with select high");

	a_wr_store: assert property (wrCommit && addr_q != csp_pkg::ADDR_REV && !isPairMsb(addr_q) && !softRst_q // [R8]
	                             |=> regs_q[$past(addr_q)] == $past(inByte))
		else $error("Write byte not stored");

	a_auto_inc: assert property (wrCommit |=> addr_q == $past(addr_q) + 6'h01) // [R10]
		else $error("Write address did not increment");

	a_pair_hold: assert property (wrCommit && isPairMsb(addr_q) && !softRst_q // [R11]
	                              |=> regs_q[$past(addr_q)] == $past(regs_q[addr_q]) && shadow_q == $past(inByte))
		else $error("High byte took effect before low byte");

	a_rd_gate: assert property (hdrDone && hdrRead && !rdEnable && !fourWire // [R12]
	                            |=> state_q == csp_pkg::CSP_DONE && !configDataOe)
		else $error("Read served without read enable");

	a_rd_drive: assert property (!selN && sckFall && state_q == csp_pkg::CSP_RD
	                             |=> configDataOut == $past(shOut_q[7])) // [R13]
		else $error("Read bit not driven on falling edge");

	a_rb_copy: assert property (fourWire && !selN |-> configReadbackOut == configDataOut) // [R14]
		else $error("Readback pin differs from data line");

	a_rb_float: assert property (configReadbackOe == !rbFloat && (fourWire || !configReadbackOut)) // [R3]
		else $error("Readback pin drive wrong");

	a_soft_rst: assert property (softRst_q |=> regs_q[csp_pkg::ADDR_SSI_B] == csp_pkg::RST_SSI_B // [R17]
	                             && regs_q[csp_pkg::ADDR_RD_EN] == 8'h00)
		else $error("Soft reset did not restore defaults");

endmodule

`default_nettype wire

//--- csp_host_model.sv
// Host controller model driving the configuration serial pins
`default_nettype none

module csp_host_model (
	// Clock
	input  wire logic clk,
	// Line levels seen by the host
	input  wire logic dataLine,
	input  wire logic rbLine,
	input  wire logic devOe,
	// Host pins
	output var logic  sck,
	output var logic  selN,
	output var logic  hostData,
	output var logic  hostOe
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] wrQ [$];
	logic [7:0] rdByte;
	logic [7:0] rbByte;
	logic       sawOe;

	initial begin
		sck = 1'b0;
		selN = 1'b1;
		hostData = 1'b0;
		hostOe = 1'b0;
		rdByte = 8'h00;
		rbByte = 8'h00;
		sawOe = 1'b0;
	end

	task automatic waitClk(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Phases of ten clocks leave room for the pin filters
	task automatic sendBit(input logic b, input logic release_);
		sck <= 1'b0;
		waitClk(5);
		hostData <= b;
		hostOe <= 1'b1;
		waitClk(5);
		sck <= 1'b1;
		waitClk(2);
		if (release_) begin
			hostOe <= 1'b0;
		end
		waitClk(8);
	endtask

	task automatic recvBit();
		sck <= 1'b0;
		waitClk(10);
		sck <= 1'b1;
		rdByte = {rdByte[6:0], dataLine};
		rbByte = {rbByte[6:0], rbLine};
		sawOe = sawOe | devOe;
		waitClk(10);
	endtask

	// Header then data, MSB first; short counts cut the transfer
	task automatic xfer(input logic rnw, input logic [5:0] addr, input int hdrBits, input int nBits);
		logic [7:0] hdr;
		int i;
		hdr = {rnw, addr, ~addr[0]};
		sawOe = 1'b0;
		selN <= 1'b0;
		waitClk(10);
		for (i = 0; i < hdrBits; i++) begin
			sendBit(hdr[7-i], rnw && i == 7);
		end
		for (i = 0; i < nBits; i++) begin
			if (rnw) begin
				recvBit();
			end else begin
				sendBit(wrQ[i/8][7-(i%8)], 1'b0);
			end
		end
		sck <= 1'b0;
		waitClk(10);
		selN <= 1'b1;
		hostOe <= 1'b0;
		waitClk(12);
	endtask
endmodule

`default_nettype wire

//--- csp_config_serial_port_test.sv
// Self-checking bench of the configuration serial port
`default_nettype none

module csp_config_serial_port_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam logic [7:0] REV = 8'h5a; // Arbitrary revision code
	localparam logic [5:0] RD_LIST [7] = '{6'h14, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h18, 6'h3f};
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         sck, selN, hostData, hostOe, lastD = 1'b0, lastR = 1'b0;
	logic         configDataOut, configDataOe, configReadbackOut, configReadbackOe;
	logic [511:0] cfgRegs;
	wire          dataLine = configDataOe ? configDataOut : (hostOe ? hostData : ~lastD);
	wire          rbLine = configReadbackOe ? configReadbackOut : ~lastR;
	logic [7:0]   model [64];
	logic [7:0]   shadow;
	logic [31:0]  rng = 32'h5929;
	int           mismatches = 0;
	int           totalChecks = 0;

	initial forever #2 clk = ~clk;
	// Floating lines change every cycle so a stale value cannot pass
	always @(posedge clk) begin
		lastD <= dataLine;
		lastR <= rbLine;
	end

	csp_config_serial_port #(.REV_ID(REV)) u_dut (
		.clk(clk), .rst_n(rst_n), .configShiftClock(sck), .configSelectN(selN),
		.configDataIn(dataLine), .configDataOut(configDataOut), .configDataOe(configDataOe),
		.configReadbackOut(configReadbackOut), .configReadbackOe(configReadbackOe), .cfgRegs(cfgRegs));

	csp_host_model u_host (
		.clk(clk), .dataLine(dataLine), .rbLine(rbLine), .devOe(configDataOe),
		.sck(sck), .selN(selN), .hostData(hostData), .hostOe(hostOe));

	// ----------------------------------------------------------------
	// Reference model and checks
	// ----------------------------------------------------------------
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic modelReset();
		foreach (model[i]) model[i] = csp_pkg::RST_OTHER;
		model[csp_pkg::ADDR_CK_CTRL] = csp_pkg::RST_CK_CTRL;
		model[csp_pkg::ADDR_CKFA_LO] = csp_pkg::RST_CKFA_LO;
		model[csp_pkg::ADDR_SSI_A] = csp_pkg::RST_SSI_A;
		model[csp_pkg::ADDR_SSI_B] = csp_pkg::RST_SSI_B;
		model[csp_pkg::ADDR_SSI_DIV] = csp_pkg::RST_SSI_DIV;
		shadow = 8'h00;
	endtask

	task automatic checkRegs(input string tn);
		for (int i = 0; i < 64; i++) check($sformatf("reg%0h", i), cfgRegs[8*i +: 8], model[i]);
		check("readbackOe", {7'h0, configReadbackOe}, {7'h0, ~model[8'h3b][3]});
		check("dataOe", {7'h0, configDataOe}, 8'h00);
		$display("test %s done", tn);
	endtask

	// Whole bytes only; the cut byte is dropped
	task automatic wr(input logic [5:0] a, input int nBits);
		u_host.xfer(1'b0, a, 8, nBits);
		for (int i = 0; i < nBits / 8; i++) begin
			if (a == 6'h3f) begin
				if (u_host.wrQ[i] == 8'h99) modelReset();
			end else if (a == 6'h15) begin
				shadow = u_host.wrQ[i];
			end else begin
				if (a == 6'h16) model[6'h15] = shadow;
				model[a] = u_host.wrQ[i];
			end
			a = a + 6'h01;
		end
		checkRegs("write");
	endtask

	task automatic wr1(input logic [5:0] a, input logic [7:0] d);
		u_host.wrQ = '{d};
		wr(a, 8);
	endtask

	task automatic rd(input logic [5:0] a);
		logic [7:0] exp;
		logic       four;
		four = model[6'h19][7];
		exp = (a == 6'h3f) ? REV : model[a];
		u_host.xfer(1'b1, a, 8, 8);
		if (model[6'h3a][3] || four) begin
			check("readData", u_host.rdByte, exp);
		end else begin
			check("refusedOe", {7'h0, u_host.sawOe}, 8'h00);
		end
		if (!model[6'h3b][3]) check("readback", u_host.rbByte, four ? exp : 8'h00);
		checkRegs("read");
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		wrap_up();
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		modelReset();
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		check("rbOut", {7'h0, configReadbackOut}, 8'h00);
		checkRegs("reset");
		rd(6'h18);
		u_host.xfer(1'b0, 6'h1f, 3, 0);
		checkRegs("cut header");
		wr1(6'h3a, 8'h08);
		u_host.wrQ = {};
		for (int i = 0; i < 5; i++) begin
			rng = xorshift(rng);
			u_host.wrQ.push_back(rng[7:0]);
		end
		wr(6'h1c, 40);
		wr(6'h1d, 21);
		foreach (RD_LIST[i]) begin
			rd(RD_LIST[i]);
		end
		wr1(6'h15, 8'h2a);
		rd(6'h15);
		wr1(6'h16, 8'h81);
		u_host.wrQ = '{8'h13, 8'h37};
		wr(6'h15, 16);
		wr1(6'h19, 8'h87);
		wr1(6'h3a, 8'h00);
		rd(6'h1c);
		wr1(6'h3b, 8'h08);
		rd(6'h1d);
		wr1(6'h3f, 8'h12);
		u_host.wrQ = '{8'h99, 8'h55};
		wr(6'h3f, 16);
		wr1(6'h3a, 8'h08);
		for (int n = 0; n < 10; n++) begin
			rng = xorshift(rng);
			u_host.wrQ = '{rng[15:8], rng[23:16], rng[31:24]};
			if (rng[0]) begin
				rd(rng[6:1]);
			end else begin
				wr(rng[6:1], 1 + rng[11:7] % 24);
			end
		end
		wrap_up();
	end
endmodule

`default_nettype wire
